// File: hdl/sdp_pkg.sv
// Shared constants and types for the synchronous dual-port RAM port logic.
// Assumes one system clock; both ports are driven from logic on that clock.
package sdp_pkg;

    // Storage geometry
    localparam int ADDR_W_DEF = 15;
    localparam int DATA_W     = 18;
    localparam int LANE_W     = 9;
    localparam int LANES      = 2;
    localparam int PORTS      = 2;

    // Lane positions inside a word
    localparam int LANE_LO    = 0;
    localparam int LANE_HI    = 1;

    // Latency select encoding: low is flow-through, high is pipelined
    localparam logic LAT_FLOW = 1'b0;
    localparam logic LAT_PIPE = 1'b1;

    // Values after reset
    localparam logic [DATA_W-1:0] DATA_RST  = 18'h00000;
    localparam int                ADDR_CLR  = 0;
    localparam logic              SEL_RST   = 1'b0;
    localparam logic [1:0]        LANE_RST  = 2'h3;
    localparam logic              STBY_RST  = 1'b1;

    // Cycle counts
    localparam int FLOW_LAT_CYC = 1;
    localparam int PIPE_LAT_CYC = 2;

    // Address counter actions
    typedef enum logic [1:0] {
        CTR_HOLD  = 2'b00,
        CTR_LOAD  = 2'b01,
        CTR_INC   = 2'b10,
        CTR_CLEAR = 2'b11
    } sdp_ctr_act_t;

endpackage

// File: hdl/sdp_addr_ctr.sv
// Loadable address counter for one RAM port.
// Assumes strobes come from logic on clk; ce freezes the counter.
`timescale 1ns/1ps
module sdp_addr_ctr #(
    parameter int ADDR_W = sdp_pkg::ADDR_W_DEF
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              ce,
    // Address controls
    input  wire logic [ADDR_W-1:0] ext_addr,
    input  wire logic              address_load_strobe_n,
    input  wire logic              increment_enable_n,
    input  wire logic              pointer_clear_n,
    // Address used by the current access and the held address
    output logic      [ADDR_W-1:0] addr_nxt,
    output logic      [ADDR_W-1:0] addr_r
);

    sdp_pkg::sdp_ctr_act_t act;

    // Clear beats load, load beats increment
    assign act = !pointer_clear_n       ? sdp_pkg::CTR_CLEAR :
                 !address_load_strobe_n ? sdp_pkg::CTR_LOAD  :
                 !increment_enable_n    ? sdp_pkg::CTR_INC   :
                                          sdp_pkg::CTR_HOLD;

    always_comb begin
        case (act)
            sdp_pkg::CTR_CLEAR: addr_nxt = ADDR_W'(sdp_pkg::ADDR_CLR);
            sdp_pkg::CTR_LOAD:  addr_nxt = ext_addr;
            sdp_pkg::CTR_INC:   addr_nxt = addr_r + ADDR_W'(1);
            default:            addr_nxt = addr_r;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_r <= ADDR_W'(sdp_pkg::ADDR_CLR);
        end else if (ce) begin
            addr_r <= addr_nxt;
        end
    end

    property p_ctr_clear;
        @(posedge clk) disable iff (sys_rst)
        (ce && !pointer_clear_n) |=> (addr_r == '0);
    endproperty
    a_ctr_clear: assert property (p_ctr_clear) else $error("counter not cleared");

    property p_ctr_load;
        @(posedge clk) disable iff (sys_rst)
        (ce && pointer_clear_n && !address_load_strobe_n) |=> (addr_r == $past(ext_addr));
    endproperty
    a_ctr_load: assert property (p_ctr_load) else $error("address not loaded");

    property p_ctr_inc;
        @(posedge clk) disable iff (sys_rst)
        (ce && pointer_clear_n && address_load_strobe_n && !increment_enable_n)
            |=> (addr_r == ADDR_W'($past(addr_r) + 1));
    endproperty
    a_ctr_inc: assert property (p_ctr_inc) else $error("counter did not advance");

    property p_ctr_hold;
        @(posedge clk) disable iff (sys_rst)
        (pointer_clear_n && address_load_strobe_n && increment_enable_n) |=> $stable(addr_r);
    endproperty
    a_ctr_hold: assert property (p_ctr_hold) else $error("held address changed");

endmodule

// File: hdl/sdp_ram.sv
// Two-port synchronous 18-bit RAM with per-port address counter and latency.
// Assumes both ports are driven by logic on clk; lane wires resolved outside.
`timescale 1ns/1ps
module sdp_ram #(
    parameter int ADDR_W = sdp_pkg::ADDR_W_DEF
) (
    // Clock, reset, clock enable
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic                      ce,
    // Port A control
    input  wire logic                      a_select_low_active,
    input  wire logic                      a_select_high_active,
    input  wire logic                      a_upper_lane_select_n,
    input  wire logic                      a_lower_lane_select_n,
    input  wire logic                      a_read_write,
    input  wire logic                      a_output_enable_n,
    input  wire logic                      a_output_latency_select,
    // Port A address
    input  wire logic [ADDR_W-1:0]         a_addr,
    input  wire logic                      a_address_load_strobe_n,
    input  wire logic                      a_increment_enable_n,
    input  wire logic                      a_pointer_clear_n,
    // Port A data
    input  wire logic [sdp_pkg::DATA_W-1:0] a_data_in,
    output logic      [sdp_pkg::DATA_W-1:0] a_data_out,
    output logic      [1:0]                 a_data_oe,
    output logic                            a_standby,
    // Port B control
    input  wire logic                      b_select_low_active,
    input  wire logic                      b_select_high_active,
    input  wire logic                      b_upper_lane_select_n,
    input  wire logic                      b_lower_lane_select_n,
    input  wire logic                      b_read_write,
    input  wire logic                      b_output_enable_n,
    input  wire logic                      b_output_latency_select,
    // Port B address
    input  wire logic [ADDR_W-1:0]         b_addr,
    input  wire logic                      b_address_load_strobe_n,
    input  wire logic                      b_increment_enable_n,
    input  wire logic                      b_pointer_clear_n,
    // Port B data
    input  wire logic [sdp_pkg::DATA_W-1:0] b_data_in,
    output logic      [sdp_pkg::DATA_W-1:0] b_data_out,
    output logic      [1:0]                 b_data_oe,
    output logic                            b_standby
);

    localparam int DEPTH = 1 << ADDR_W;
    localparam int DW    = sdp_pkg::DATA_W;
    localparam int LW    = sdp_pkg::LANE_W;
    localparam int NP    = sdp_pkg::PORTS;

    // Selected when the low-active enable is low and the high-active one high
    function automatic logic port_sel(input logic en_low, input logic en_high);
        port_sel = !en_low && en_high;
    endfunction

    // Gathered port inputs, index 0 is port A
    logic [NP-1:0]         sel_lo_w;
    logic [NP-1:0]         sel_hi_w;
    logic [NP-1:0]         up_n_w;
    logic [NP-1:0]         lo_n_w;
    logic [NP-1:0]         rw_w;
    logic [NP-1:0]         oe_n_w;
    logic [NP-1:0]         lat_w;
    logic [NP-1:0]         ld_n_w;
    logic [NP-1:0]         inc_n_w;
    logic [NP-1:0]         clr_n_w;
    logic [ADDR_W-1:0]     ext_addr_w [NP];
    logic [DW-1:0]         din_w      [NP];

    // Per-port internal state
    logic [ADDR_W-1:0]     addr_nxt   [NP];
    logic [ADDR_W-1:0]     addr_r     [NP];
    logic [NP-1:0]         sel_now;
    logic [1:0]            we_lane    [NP];
    logic [NP-1:0]         we_any;
    logic [DW-1:0]         rd_now     [NP];
    logic [DW-1:0]         flow_r     [NP];
    logic [DW-1:0]         dout_r     [NP];
    logic [NP-1:0]         sel1_r;
    logic [NP-1:0]         sel2_r;
    logic [NP-1:0]         rd1_r;
    logic [NP-1:0]         rd2_r;
    logic [1:0]            lane_r     [NP];
    logic [NP-1:0]         stby_r;
    logic [NP-1:0]         sel_eff;
    logic [NP-1:0]         rd_eff;
    logic [1:0]            oe_sync    [NP];
    logic [1:0]            oe_out     [NP];
    logic [NP-1:0]         coll;

    logic [DW-1:0]         mem [DEPTH];

    assign sel_lo_w   = {b_select_low_active, a_select_low_active};
    assign sel_hi_w   = {b_select_high_active, a_select_high_active};
    assign up_n_w     = {b_upper_lane_select_n, a_upper_lane_select_n};
    assign lo_n_w     = {b_lower_lane_select_n, a_lower_lane_select_n};
    assign rw_w       = {b_read_write, a_read_write};
    assign oe_n_w     = {b_output_enable_n, a_output_enable_n};
    assign lat_w      = {b_output_latency_select, a_output_latency_select};
    assign ld_n_w     = {b_address_load_strobe_n, a_address_load_strobe_n};
    assign inc_n_w    = {b_increment_enable_n, a_increment_enable_n};
    assign clr_n_w    = {b_pointer_clear_n, a_pointer_clear_n};
    assign ext_addr_w[0] = a_addr;
    assign ext_addr_w[1] = b_addr;
    assign din_w[0]   = a_data_in;
    assign din_w[1]   = b_data_in;

    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_port

            // Counter acts on every enabled edge, whatever the chip enables say
            sdp_addr_ctr #(
                .ADDR_W                (ADDR_W)
            ) u_ctr (
                .clk                   (clk),
                .sys_rst               (sys_rst),
                .ce                    (ce),
                .ext_addr              (ext_addr_w[p]),
                .address_load_strobe_n (ld_n_w[p]),
                .increment_enable_n    (inc_n_w[p]),
                .pointer_clear_n       (clr_n_w[p]),
                .addr_nxt              (addr_nxt[p]),
                .addr_r                (addr_r[p])
            );

            assign sel_now[p]   = port_sel(sel_lo_w[p], sel_hi_w[p]);
            // Write strobes per lane; both selects high leave the word alone
            assign we_lane[p][sdp_pkg::LANE_HI] = ce && sel_now[p] && !rw_w[p]
                                                  && !up_n_w[p];
            assign we_lane[p][sdp_pkg::LANE_LO] = ce && sel_now[p] && !rw_w[p]
                                                  && !lo_n_w[p];
            assign we_any[p]    = |we_lane[p];
            assign rd_now[p]    = mem[addr_nxt[p]];

            // Flow-through uses one enable stage, pipelined two
            assign sel_eff[p]   = (lat_w[p] == sdp_pkg::LAT_PIPE) ? sel2_r[p] : sel1_r[p];
            assign rd_eff[p]    = (lat_w[p] == sdp_pkg::LAT_PIPE) ? rd2_r[p]  : rd1_r[p];
            assign oe_sync[p]   = {2{sel_eff[p] && rd_eff[p]}} & ~lane_r[p];
            // Output enable gates the lanes without waiting for a clock edge
            assign oe_out[p]    = oe_sync[p] & {2{!oe_n_w[p]}};

            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    flow_r[p] <= sdp_pkg::DATA_RST;
                    dout_r[p] <= sdp_pkg::DATA_RST;
                    sel1_r[p] <= sdp_pkg::SEL_RST;
                    sel2_r[p] <= sdp_pkg::SEL_RST;
                    rd1_r[p]  <= sdp_pkg::SEL_RST;
                    rd2_r[p]  <= sdp_pkg::SEL_RST;
                    lane_r[p] <= sdp_pkg::LANE_RST;
                    stby_r[p] <= sdp_pkg::STBY_RST;
                end else if (ce) begin
                    flow_r[p] <= rd_now[p];
                    dout_r[p] <= (lat_w[p] == sdp_pkg::LAT_PIPE) ? flow_r[p]
                                                                  : rd_now[p];
                    sel1_r[p] <= sel_now[p];
                    sel2_r[p] <= sel1_r[p];
                    rd1_r[p]  <= rw_w[p];
                    rd2_r[p]  <= rd1_r[p];
                    lane_r[p] <= {up_n_w[p], lo_n_w[p]};
                    stby_r[p] <= !sel_now[p];
                end
            end

            assign coll[p] = we_any[NP-1-p] && (addr_nxt[0] == addr_nxt[1]);

            property p_flow_lat;
                @(posedge clk) disable iff (sys_rst)
                (!$past(sys_rst) && $past(ce) && $past(lat_w[p]) == sdp_pkg::LAT_FLOW)
                    |-> (dout_r[p] === $past(rd_now[p]));
            endproperty
            a_flow_lat: assert property (p_flow_lat) else $error("flow data wrong");

            property p_pipe_lat;
                @(posedge clk) disable iff (sys_rst)
                (!$past(sys_rst) && !$past(sys_rst, 2) && $past(ce) && $past(ce, 2)
                 && $past(lat_w[p]) == sdp_pkg::LAT_PIPE)
                    |-> (dout_r[p] === $past(rd_now[p], 2));
            endproperty
            a_pipe_lat: assert property (p_pipe_lat) else $error("pipe data not delayed");

            property p_lane_reg;
                @(posedge clk) disable iff (sys_rst)
                ce |=> (lane_r[p] == $past({up_n_w[p], lo_n_w[p]}));
            endproperty
            a_lane_reg: assert property (p_lane_reg) else $error("lane select stage wrong");

            property p_desel_pipe;
                @(posedge clk) disable iff (sys_rst)
                (ce && !sel_now[p]) ##1 ce |=> !sel2_r[p];
            endproperty
            a_desel_pipe: assert property (p_desel_pipe) else $error("deselect late");

            property p_standby;
                @(posedge clk) disable iff (sys_rst)
                (ce && !sel_now[p] && lat_w[p] == sdp_pkg::LAT_FLOW)
                    |=> (stby_r[p] && oe_out[p] == 2'h0);
            endproperty
            a_standby: assert property (p_standby) else $error("deselected port drives");

            property p_oe_gate;
                @(posedge clk) disable iff (sys_rst)
                (oe_out[p] != 2'h0) |-> (!oe_n_w[p] && rd_eff[p] && sel_eff[p]
                                         && ((oe_out[p] & lane_r[p]) == 2'h0));
            endproperty
            a_oe_gate: assert property (p_oe_gate) else $error("lane driven wrongly");

            property p_wr_upper;
                @(posedge clk) disable iff (sys_rst)
                (we_lane[p][sdp_pkg::LANE_HI] && !coll[p])
                    |=> (mem[$past(addr_nxt[p])][DW-1:LW] == $past(din_w[p][DW-1:LW]));
            endproperty
            a_wr_upper: assert property (p_wr_upper) else $error("upper byte not written");

            property p_wr_keep_upper;
                @(posedge clk) disable iff (sys_rst)
                (ce && sel_now[p] && !rw_w[p] && up_n_w[p] && !coll[p])
                    |=> (mem[$past(addr_nxt[p])][DW-1:LW]
                         == $past(mem[addr_nxt[p]][DW-1:LW]));
            endproperty
            a_wr_keep_upper: assert property (p_wr_keep_upper) else $error("upper byte hit");

            property p_wr_lower;
                @(posedge clk) disable iff (sys_rst)
                (we_lane[p][sdp_pkg::LANE_LO] && !coll[p])
                    |=> (mem[$past(addr_nxt[p])][LW-1:0] == $past(din_w[p][LW-1:0]));
            endproperty
            a_wr_lower: assert property (p_wr_lower) else $error("lower byte not written");

            property p_wr_keep_lower;
                @(posedge clk) disable iff (sys_rst)
                (ce && sel_now[p] && !rw_w[p] && lo_n_w[p] && !coll[p])
                    |=> (mem[$past(addr_nxt[p])][LW-1:0]
                         === $past(mem[addr_nxt[p]][LW-1:0]));
            endproperty
            a_wr_keep_lower: assert property (p_wr_keep_lower) else $error("lower byte hit");

            property p_desel_hold;
                @(posedge clk) disable iff (sys_rst)
                (!sel_now[p] && !coll[p])
                    |=> (mem[$past(addr_nxt[p])] === $past(mem[addr_nxt[p]]));
            endproperty
            a_desel_hold: assert property (p_desel_hold) else $error("idle port wrote");

            property p_sel_stage;
                @(posedge clk) disable iff (sys_rst)
                ce |=> (sel1_r[p] == $past(sel_now[p]) && sel2_r[p] == $past(sel1_r[p]));
            endproperty
            a_sel_stage: assert property (p_sel_stage) else $error("enable stages wrong");

            property p_wr_no_drive;
                @(posedge clk) disable iff (sys_rst)
                (ce && sel_now[p] && !rw_w[p] && lat_w[p] == sdp_pkg::LAT_FLOW)
                    |=> (oe_out[p] == 2'h0);
            endproperty
            a_wr_no_drive: assert property (p_wr_no_drive) else $error("write drives");
        end
    endgenerate

    // Both ports write in one process; on a same-word clash port B lands last
    always_ff @(posedge clk) begin
        for (int i = 0; i < NP; i++) begin
            if (we_lane[i][sdp_pkg::LANE_LO]) begin
                mem[addr_nxt[i]][LW-1:0] <= din_w[i][LW-1:0];
            end
            if (we_lane[i][sdp_pkg::LANE_HI]) begin
                mem[addr_nxt[i]][DW-1:LW] <= din_w[i][DW-1:LW];
            end
        end
    end

    assign a_data_out = dout_r[0];
    assign b_data_out = dout_r[1];
    assign a_data_oe  = oe_out[0];
    assign b_data_oe  = oe_out[1];
    assign a_standby  = stby_r[0];
    assign b_standby  = stby_r[1];

endmodule

// File: verification/sdp_master_model.sv
// Bus master model for one RAM port: drives controls, address and write data.
// Assumes the port samples on the rising edge; the model changes lines on the falling one.
`timescale 1ns/1ps
module sdp_master_model #(
    parameter int ADDR_W = sdp_pkg::ADDR_W_DEF
) (
    // Clock
    input  wire logic                       clk,
    // Port controls
    output logic                            select_low_active,
    output logic                            select_high_active,
    output logic                            upper_lane_select_n,
    output logic                            lower_lane_select_n,
    output logic                            read_write,
    output logic                            output_enable_n,
    output logic                            output_latency_select,
    // Address controls
    output logic      [ADDR_W-1:0]          addr,
    output logic                            address_load_strobe_n,
    output logic                            increment_enable_n,
    output logic                            pointer_clear_n,
    // Write data
    output logic      [sdp_pkg::DATA_W-1:0] data_in
);
    initial begin
        select_low_active     = 1'b1;
        select_high_active    = 1'b0;
        upper_lane_select_n   = 1'b1;
        lower_lane_select_n   = 1'b1;
        read_write            = 1'b1;
        output_enable_n       = 1'b0;
        output_latency_select = sdp_pkg::LAT_FLOW;
        addr                  = '0;
        address_load_strobe_n = 1'b1;
        increment_enable_n    = 1'b1;
        pointer_clear_n       = 1'b1;
        data_in               = 18'h15555;
    end

    // One bus cycle; everything stays put until the next call
    task automatic cyc(input logic s, input sdp_pkg::sdp_ctr_act_t c, input logic [ADDR_W-1:0] a,
                       input logic wr, input logic [1:0] ln, input logic [17:0] d);
        @(negedge clk);
        select_low_active     = ~s;
        select_high_active    = s;
        upper_lane_select_n   = ln[1];
        lower_lane_select_n   = ln[0];
        addr                  = a;
        address_load_strobe_n = !(c == sdp_pkg::CTR_LOAD || c == sdp_pkg::CTR_CLEAR);
        increment_enable_n    = (c != sdp_pkg::CTR_INC);
        pointer_clear_n       = (c != sdp_pkg::CTR_CLEAR);
        // Never write in a CTR_LOAD cycle; a CTR_CLEAR cycle also pulls the load strobe low but can still write
        read_write            = ~wr | (c == sdp_pkg::CTR_LOAD);
        // Unused data lines toggle so a stale word never looks valid
        data_in               = read_write ? ~data_in : d;
    endtask

    task automatic set_mode(input logic oe_n, input logic lat);
        @(negedge clk);
        output_enable_n       = oe_n;
        output_latency_select = lat;
    endtask
endmodule

// File: verification/sdp_ram_tb.sv
// Self-checking bench for the dual-port RAM port logic.
// Assumes two master models drive ports A and B; one scenario drops clock enable.
`timescale 1ns/1ps
module sdp_ram_tb;
    localparam int AW = 15;
    localparam sdp_pkg::sdp_ctr_act_t HD = sdp_pkg::CTR_HOLD;
    localparam sdp_pkg::sdp_ctr_act_t LD = sdp_pkg::CTR_LOAD;
    localparam sdp_pkg::sdp_ctr_act_t IN = sdp_pkg::CTR_INC;
    localparam sdp_pkg::sdp_ctr_act_t CL = sdp_pkg::CTR_CLEAR;
    logic          clk = 1'b0;
    logic          sys_rst = 1'b1;
    logic          ce = 1'b1;
    int            fail_count = 0;
    int            tests_run = 0;
    wire logic     a_sl, a_sh, a_up, a_lo, a_rw, a_oe, a_lat, a_ldn, a_inc, a_clr, a_sby;
    wire logic     b_sl, b_sh, b_up, b_lo, b_rw, b_oe, b_lat, b_ldn, b_inc, b_clr, b_sby;
    wire logic [AW-1:0] a_adr, b_adr;
    wire logic [17:0]   a_di, a_do, b_di, b_do;
    wire logic [1:0]    a_doe, b_doe;

    always #10 clk = ~clk;

    sdp_ram #(.ADDR_W(AW)) sdp_ram_i (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .a_select_low_active(a_sl), .a_select_high_active(a_sh), .a_upper_lane_select_n(a_up),
        .a_lower_lane_select_n(a_lo), .a_read_write(a_rw), .a_output_enable_n(a_oe),
        .a_output_latency_select(a_lat), .a_addr(a_adr), .a_address_load_strobe_n(a_ldn),
        .a_increment_enable_n(a_inc), .a_pointer_clear_n(a_clr), .a_data_in(a_di),
        .a_data_out(a_do), .a_data_oe(a_doe), .a_standby(a_sby),
        .b_select_low_active(b_sl), .b_select_high_active(b_sh), .b_upper_lane_select_n(b_up),
        .b_lower_lane_select_n(b_lo), .b_read_write(b_rw), .b_output_enable_n(b_oe),
        .b_output_latency_select(b_lat), .b_addr(b_adr), .b_address_load_strobe_n(b_ldn),
        .b_increment_enable_n(b_inc), .b_pointer_clear_n(b_clr), .b_data_in(b_di),
        .b_data_out(b_do), .b_data_oe(b_doe), .b_standby(b_sby));

    sdp_master_model #(.ADDR_W(AW)) master_a (.clk(clk), .select_low_active(a_sl),
        .select_high_active(a_sh), .upper_lane_select_n(a_up), .lower_lane_select_n(a_lo),
        .read_write(a_rw), .output_enable_n(a_oe), .output_latency_select(a_lat), .addr(a_adr),
        .address_load_strobe_n(a_ldn), .increment_enable_n(a_inc), .pointer_clear_n(a_clr),
        .data_in(a_di));

    sdp_master_model #(.ADDR_W(AW)) master_b (.clk(clk), .select_low_active(b_sl),
        .select_high_active(b_sh), .upper_lane_select_n(b_up), .lower_lane_select_n(b_lo),
        .read_write(b_rw), .output_enable_n(b_oe), .output_latency_select(b_lat), .addr(b_adr),
        .address_load_strobe_n(b_ldn), .increment_enable_n(b_inc), .pointer_clear_n(b_clr),
        .data_in(b_di));

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Let the taking edge pass and its updates land
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    // Port A write: load cycle with read held, then the write
    task automatic wr(input logic [AW-1:0] a, input logic [1:0] ln, input logic [17:0] d);
        master_a.cyc(1'b1, LD, a, 1'b0, 2'h3, d);
        master_a.cyc(1'b1, HD, a, 1'b1, ln, d);
    endtask

    // Port A flow-through read; data judged only when both lanes drive
    task automatic rd(input logic s, input sdp_pkg::sdp_ctr_act_t c, input logic [AW-1:0] a,
                      input logic [1:0] ln, input logic [17:0] e, input logic [1:0] eo);
        master_a.cyc(s, c, a, 1'b0, ln, 18'h0);
        tick();
        if (eo == 2'h3)
            chk(a_do, e);
        chk({16'h0, a_doe}, {16'h0, eo});
    endtask

    task automatic t_word();
        wr(15'h7fff, 2'h0, 18'h2a5c3);
        fork
            rd(1'b1, LD, 15'h7fff, 2'h0, 18'h2a5c3, 2'h3);
            master_b.cyc(1'b1, LD, 15'h7fff, 1'b0, 2'h0, 18'h0);
        join
        chk(b_do, 18'h2a5c3);
        master_b.cyc(1'b0, HD, 15'h0000, 1'b0, 2'h3, 18'h0);
    endtask

    task automatic t_lanes();
        wr(15'h0005, 2'h0, 18'h00000);
        wr(15'h0005, 2'h2, 18'h155aa);
        wr(15'h0005, 2'h1, 18'h2b400);
        wr(15'h0005, 2'h3, 18'h3ffff);
        rd(1'b1, LD, 15'h0005, 2'h0, 18'h2b5aa, 2'h3);
        rd(1'b1, HD, 15'h0005, 2'h1, 18'h0, 2'h2);
        rd(1'b1, HD, 15'h0005, 2'h2, 18'h0, 2'h1);
        rd(1'b1, HD, 15'h0005, 2'h3, 18'h0, 2'h0);
    endtask

    task automatic t_counter();
        wr(15'h0000, 2'h0, 18'h00011);
        wr(15'h0001, 2'h0, 18'h00022);
        wr(15'h0002, 2'h0, 18'h00033);
        rd(1'b0, LD, 15'h0001, 2'h0, 18'h0, 2'h0);
        chk({17'h0, a_sby}, 18'h1);
        rd(1'b1, HD, 15'h0002, 2'h0, 18'h00022, 2'h3);
        chk({17'h0, a_sby}, 18'h0);
        rd(1'b0, IN, 15'h0000, 2'h0, 18'h0, 2'h0);
        rd(1'b1, HD, 15'h0000, 2'h0, 18'h00033, 2'h3);
        rd(1'b1, CL, 15'h0002, 2'h0, 18'h00011, 2'h3);
        rd(1'b1, IN, 15'h0002, 2'h0, 18'h00022, 2'h3);
    endtask

    task automatic t_pipe();
        master_b.set_mode(1'b0, sdp_pkg::LAT_PIPE);
        master_b.cyc(1'b1, LD, 15'h0005, 1'b0, 2'h0, 18'h0);
        tick();
        chk({16'h0, b_doe}, 18'h0);
        chk({17'h0, b_sby}, 18'h0);
        master_b.cyc(1'b1, HD, 15'h0000, 1'b0, 2'h0, 18'h0);
        tick();
        chk(b_do, 18'h2b5aa);
        chk({16'h0, b_doe}, 18'h3);
        master_b.cyc(1'b1, HD, 15'h0000, 1'b0, 2'h1, 18'h0);
        tick();
        chk({16'h0, b_doe}, 18'h2);
        master_b.cyc(1'b0, HD, 15'h0000, 1'b0, 2'h1, 18'h0);
        tick();
        chk({16'h0, b_doe}, 18'h2);
        chk({17'h0, b_sby}, 18'h1);
        tick();
        chk({16'h0, b_doe}, 18'h0);
    endtask

    task automatic t_oe();
        rd(1'b1, LD, 15'h0005, 2'h0, 18'h2b5aa, 2'h3);
        master_a.set_mode(1'b1, sdp_pkg::LAT_FLOW);
        #1;
        chk({16'h0, a_doe}, 18'h0);
        master_a.set_mode(1'b0, sdp_pkg::LAT_FLOW);
        #1;
        chk({16'h0, a_doe}, 18'h3);
    endtask

    // Clock enable low: no increment, no write, outputs hold
    task automatic t_freeze();
        @(negedge clk);
        ce = 1'b0;
        master_a.cyc(1'b1, IN, 15'h0000, 1'b1, 2'h0, 18'h3ffff);
        tick();
        chk(a_do, 18'h2b5aa);
        master_a.cyc(1'b1, HD, 15'h0000, 1'b0, 2'h0, 18'h0);
        ce = 1'b1;
        tick();
        chk(a_do, 18'h2b5aa);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        chk({16'h0, a_doe}, 18'h0);
        chk({17'h0, a_sby}, 18'h1);
        t_word();
        t_lanes();
        t_counter();
        t_pipe();
        t_oe();
        t_freeze();
        finish_test();
    end

    // Cuts a hung run short
    initial begin
        repeat (2000) @(posedge clk);
        fail_count++;
        $display("CHECK FAILED t=%0t run did not end in time", $time);
        finish_test();
    end
endmodule
